// ### logic/blps_pkg.sv
// Constants, types and strap table of the boot loader block
package blps_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_PLLCFG = 8'h04;
   localparam logic [7:0] OFF_LENGTH = 8'h08;
   localparam logic [7:0] OFF_CRC = 8'h0c;
   localparam logic [7:0] OFF_CHECK = 8'h10;
   localparam logic [7:0] OFF_SECURE = 8'h14;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int RST_DLY_MIN_US = 15;
   localparam int RST_DLY_CYC = (RST_DLY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W = 10;
   localparam int FL_HALF_CYC = 4;
   // ----------------------------------------------------------------
   // Flash, image and CRC constants
   // ----------------------------------------------------------------
   localparam logic [7:0] FL_CMD = 8'h6b;
   localparam logic [23:0] FL_ADDR = 24'h000000;
   localparam int FL_DUMMY = 8;
   localparam logic [31:0] SKIP_WORD = 32'h0d15ab1e;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'h0fffffff;
   localparam int SEC_BOOT_BIT = 5;
   localparam logic [31:0] BOOT_PC = 32'h00000000;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_HOLD = 9'h001, ST_DLY = 9'h002, ST_SEL = 9'h004, ST_OTP = 9'h008,
      ST_LEN = 9'h010, ST_PROG = 9'h020, ST_CHK = 9'h040, ST_RUN = 9'h080,
      ST_FAIL = 9'h100
   } blps_st_t;
   typedef enum logic [3:0] {
      Q_IDLE = 4'h1, Q_CMD = 4'h2, Q_DUM = 4'h4, Q_DAT = 4'h8
   } blps_qst_t;
   typedef struct packed {
      logic [2:0] pll_output_divider;
      logic [11:0] f;
      logic [5:0] r;
   } blps_pll_t;
   typedef struct packed {
      logic [7:0] ratio;
      blps_pll_t pll;
   } blps_boot_t;
   typedef struct packed {
      logic [4:0] rsv2;
      logic [2:0] pll_output_divider;
      logic [3:0] rsv1;
      logic [11:0] f;
      logic [1:0] rsv0;
      logic [5:0] r;
   } blps_pllreg_t;
   typedef struct packed {
      logic [7:0] ratio;
      logic [6:0] rsv1;
      logic [8:0] state;
      logic [1:0] rsv0;
      logic [1:0] strap;
      logic busy;
      logic otp;
      logic fail;
      logic run;
   } blps_status_t;
   // Strap pattern to boot ratio and PLL settings
   function automatic blps_boot_t blps_boot_cfg(input logic [1:0] strap);
      blps_boot_t b;
      b.pll.pll_output_divider = 3'h1;
      b.pll.r = 6'h00;
      case (strap)
         2'h0: begin
            b.ratio = 8'h28;
            b.pll.f = 12'h09f;
         end
         2'h3: begin
            b.ratio = 8'h10;
            b.pll.f = 12'h03f;
         end
         2'h2: begin
            b.ratio = 8'h08;
            b.pll.f = 12'h01f;
         end
         default: begin
            b.ratio = 8'h04;
            b.pll.f = 12'h00f;
         end
      endcase
      return b;
   endfunction: blps_boot_cfg
   localparam blps_boot_t BOOT_RST = blps_boot_cfg(2'h0);
endpackage: blps_pkg

// ### logic/blps_crc32.sv
// Byte-wide reflected CRC-32 engine for the boot image stream
module blps_crc32 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] din,
   output logic [31:0] crc_o
);
   typedef struct packed {
      logic [31:0] c;
   } blps_cs_t;
   blps_cs_t r, n;
   // Preset or fold one byte, low bit first
   always_comb begin
      n = r;
      if (init) begin
         n.c = blps_pkg::CRC_INIT;
      end else if (en) begin
         n.c = r.c ^ {24'h000000, din};
         for (int i = 0; i < 8; i++) begin
            n.c = n.c[0] ? ({1'h0, n.c[31:1]} ^ blps_pkg::CRC_POLY) :
                  {1'h0, n.c[31:1]};
         end
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   // Inverted residue is the CRC
   assign crc_o = ~r.c;
   init_crc_a: assert property (@(posedge clk) disable iff (!rst_n)
      init |=> crc_o == ~blps_pkg::CRC_INIT)
      else $error("crc preset wrong");
endmodule: blps_crc32

// ### logic/blps_qspi_rd.sv
// Quad-output serial flash reader streaming bytes from address zero
module blps_qspi_rd #(
   parameter int HALF = blps_pkg::FL_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [3:0] io_i,
   output logic sck,
   output logic cs_n,
   output logic [3:0] io_o,
   output logic [3:0] io_oe,
   output logic byte_vld,
   output logic [7:0] byte_data
);
   if (HALF < 3 || HALF > 255) $error("HALF must be 3..255");
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      blps_pkg::blps_qst_t st;
      logic [7:0] div;
      logic sck;
      logic [31:0] sh;
      logic [5:0] bits;
      logic nib;
      logic [7:0] dat;
      logic vld;
   } blps_qs_t;
   blps_qs_t r, n;
   logic tick;
   // Command, address, dummy clocks, then quad data high nibble first
   always_comb begin
      n = r;
      n.s1 = io_i;
      n.s2 = r.s1;
      n.vld = 1'h0;
      tick = r.div == 8'(HALF - 1);
      n.div = tick ? 8'h00 : r.div + 8'h01;
      unique case (r.st)
         blps_pkg::Q_IDLE: begin
            n.sck = 1'h0;
            n.div = 8'h00;
            if (go) begin
               n.st = blps_pkg::Q_CMD;
               n.sh = {blps_pkg::FL_CMD, blps_pkg::FL_ADDR};
               n.bits = 6'h1f;
            end
         end
         blps_pkg::Q_CMD: if (tick) begin
            n.sck = !r.sck;
            if (!r.sck) begin
               if (r.bits == 6'h00) begin
                  n.st = blps_pkg::Q_DUM;
                  n.bits = 6'(blps_pkg::FL_DUMMY - 1);
               end else begin
                  n.bits = r.bits - 6'h01;
               end
            end else begin
               n.sh = {r.sh[30:0], 1'h0};
            end
         end
         blps_pkg::Q_DUM: if (tick) begin
            n.sck = !r.sck;
            if (!r.sck) begin
               if (r.bits == 6'h00) begin
                  n.st = blps_pkg::Q_DAT;
                  n.nib = 1'h0;
               end else begin
                  n.bits = r.bits - 6'h01;
               end
            end
         end
         blps_pkg::Q_DAT: if (tick) begin
            n.sck = !r.sck;
            if (!r.sck) begin
               n.nib = !r.nib;
               if (!r.nib) begin
                  n.dat = {r.s2, r.dat[3:0]};
               end else begin
                  n.dat = {r.dat[7:4], r.s2};
                  n.vld = 1'h1;
               end
            end
         end
      endcase
      // Dropping go ends the read at once
      if (!go) begin
         n.st = blps_pkg::Q_IDLE;
         n.sck = 1'h0;
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= blps_pkg::Q_IDLE;
      end else begin
         r <= n;
      end
   end
   // Pin and stream outputs
   assign sck = r.sck;
   assign cs_n = r.st == blps_pkg::Q_IDLE;
   assign io_o = {3'h0, r.sh[31]};
   assign io_oe = {3'h0, r.st == blps_pkg::Q_CMD};
   assign byte_vld = r.vld;
   assign byte_data = r.dat;
   idle_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
      !go |=> cs_n && !sck && io_oe == 4'h0)
      else $error("flash pins active while idle");
endmodule: blps_qspi_rd

// ### logic/blps_boot_top.sv
// Boot sequencer top: reset hold, strap PLL, flash image load, APB registers
//
// Contract
// - Reset held, GPIO pull-downs while pin low
// - Internal reset delay then boot
// - Straps pick PLL ratio 40/16/8/4
// - Boot settings divider 1, ref 0, F table
// - Tile clock follows F, R, divider formula
// - PLL fields rewritable at run time
// - PLL clocks switch, tile and reference
// - Security bit 5 selects OTP boot
// - Image fetched over tile 0 flash
// - Image starts with length in words
// - Check word skip value bypasses CRC
// - Length and check words LSB first
// - Load and start at RAM address zero
// - CRC covers length and program bytes
// - Reflected polynomial, preset, inverted residue
// - Secure boot starts OTP at zero
//
// Design decisions made here: the register addresses and the APB register port.
module blps_boot_top #(
   parameter int RAM_AW = 15,
   parameter int FL_HALF = blps_pkg::FL_HALF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_rst_n,
   input wire logic [1:0] strap_pins,
   input wire logic [31:0] security_word,
   output logic gpio_pulldown_en,
   output logic core_rst,
   output logic otp_boot,
   output logic boot_fail,
   output logic [31:0] start_addr,
   output blps_pkg::blps_pll_t pll_cfg,
   output logic ram_we,
   output logic [RAM_AW-1:0] ram_addr,
   output logic [31:0] ram_wdata,
   output logic flash_sck,
   output logic flash_cs_n,
   output logic [3:0] flash_io_o,
   output logic [3:0] flash_io_oe,
   input wire logic [3:0] flash_io_i
);
   // ----------------------------------------------------------------
   // Elaboration checks and local constants
   // ----------------------------------------------------------------
   if (RAM_AW < 1 || RAM_AW > 30) $error("RAM_AW must be 1..30");
   if (blps_pkg::RST_DLY_CYC >= 2 ** blps_pkg::RST_CNT_W) $error("delay counter too narrow");
   localparam logic [31:0] RAM_WORDS = 32'(2 ** RAM_AW);
   localparam int DLY_CYC = blps_pkg::RST_DLY_CYC;
   localparam int DLY_HIST = blps_pkg::RST_DLY_CYC + 1;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [1:0] strap_s1;
      logic [1:0] strap_s2;
      blps_pkg::blps_st_t st;
      logic [blps_pkg::RST_CNT_W-1:0] cnt;
      logic [1:0] strap;
      logic [7:0] ratio;
      blps_pkg::blps_pll_t pll;
      logic otp;
      logic run;
      logic fail;
      logic qrun;
      logic [1:0] bcnt;
      logic [31:0] word;
      logic [31:0] len;
      logic [31:0] widx;
      logic [31:0] chk;
      logic we;
      logic [RAM_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic err;
   } blps_ms_t;

   blps_ms_t r, n;
   logic byte_vld;
   logic [7:0] byte_data;
   logic [31:0] crc_val;
   logic crc_init;
   logic crc_en;
   logic in_image;
   logic wdone;
   logic [31:0] wd;
   blps_pkg::blps_status_t status_w;
   blps_pkg::blps_pllreg_t pllreg_w;
   blps_pkg::blps_pllreg_t pllwr_w;
   blps_pkg::blps_boot_t boot_w;

   // ----------------------------------------------------------------
   // Flash reader and CRC engine
   // ----------------------------------------------------------------
   // Serial flash on tile 0 port pins
   blps_qspi_rd #(
      .HALF(FL_HALF)
   ) u_flash (
      .clk(pclk),
      .rst_n(presetn),
      .go(r.qrun),
      .io_i(flash_io_i),
      .sck(flash_sck),
      .cs_n(flash_cs_n),
      .io_o(flash_io_o),
      .io_oe(flash_io_oe),
      .byte_vld(byte_vld),
      .byte_data(byte_data)
   );

   // CRC sees length and program bytes only
   assign crc_init = r.st == blps_pkg::ST_SEL;
   assign crc_en = byte_vld && (r.st == blps_pkg::ST_LEN || r.st == blps_pkg::ST_PROG);

   blps_crc32 u_crc (
      .clk(pclk),
      .rst_n(presetn),
      .init(crc_init),
      .en(crc_en),
      .din(byte_data),
      .crc_o(crc_val)
   );

   // ----------------------------------------------------------------
   // Word assembly and register views
   // ----------------------------------------------------------------
   // Bytes gather low byte first into words
   assign in_image = r.st == blps_pkg::ST_LEN || r.st == blps_pkg::ST_PROG ||
                     r.st == blps_pkg::ST_CHK;
   assign wd = {byte_data, r.word[31:8]};
   assign wdone = in_image && byte_vld && r.bcnt == 2'h3;
   assign boot_w = blps_pkg::blps_boot_cfg(r.strap_s2);

   // Status and PLL register layouts
   always_comb begin
      status_w = '0;
      status_w.ratio = r.ratio;
      status_w.state = r.st;
      status_w.strap = r.strap;
      status_w.busy = r.qrun;
      status_w.otp = r.otp;
      status_w.fail = r.fail;
      status_w.run = r.run;
      pllreg_w = '0;
      pllreg_w.pll_output_divider = r.pll.pll_output_divider;
      pllreg_w.f = r.pll.f;
      pllreg_w.r = r.pll.r;
      pllwr_w = pwdata;
   end

   // ----------------------------------------------------------------
   // Next state: APB slave and boot sequence
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.rst_s1 = chip_rst_n;
      n.rst_s2 = r.rst_s1;
      n.strap_s1 = strap_pins;
      n.strap_s2 = r.strap_s1;
      n.we = 1'h0;
      // Setup phase latches read data and error
      if (psel && !penable) begin
         n.err = 1'h0;
         case (paddr)
            blps_pkg::OFF_STATUS: n.rdata = status_w;
            blps_pkg::OFF_PLLCFG: n.rdata = pllreg_w;
            blps_pkg::OFF_LENGTH: n.rdata = r.len;
            blps_pkg::OFF_CRC: n.rdata = crc_val;
            blps_pkg::OFF_CHECK: n.rdata = r.chk;
            blps_pkg::OFF_SECURE: n.rdata = security_word;
            default: begin
               n.rdata = 32'h00000000;
               n.err = 1'h1;
            end
         endcase
      end
      // Access phase write to PLL settings
      if (psel && penable && pwrite && paddr == blps_pkg::OFF_PLLCFG) begin
         n.pll.pll_output_divider = pllwr_w.pll_output_divider;
         n.pll.f = pllwr_w.f;
         n.pll.r = pllwr_w.r;
      end
      // Byte collection during image fetch
      if (in_image && byte_vld) begin
         n.word = wd;
         n.bcnt = r.bcnt + 2'h1;
      end
      unique case (r.st)
         blps_pkg::ST_HOLD: if (r.rst_s2) begin
            n.st = blps_pkg::ST_DLY;
            n.cnt = '0;
            n.strap = r.strap_s2;
            n.ratio = boot_w.ratio;
            n.pll = boot_w.pll;
         end
         blps_pkg::ST_DLY: begin
            if (r.cnt == blps_pkg::RST_CNT_W'(DLY_CYC - 1)) begin
               n.st = blps_pkg::ST_SEL;
            end else begin
               n.cnt = r.cnt + 1'h1;
            end
         end
         blps_pkg::ST_SEL: begin
            if (security_word[blps_pkg::SEC_BOOT_BIT]) begin
               n.st = blps_pkg::ST_OTP;
               n.otp = 1'h1;
            end else begin
               n.st = blps_pkg::ST_LEN;
               n.qrun = 1'h1;
               n.bcnt = 2'h0;
            end
         end
         blps_pkg::ST_LEN: if (wdone) begin
            n.len = wd;
            n.widx = 32'h00000000;
            if (wd == 32'h00000000) begin
               n.st = blps_pkg::ST_CHK;
            end else if (wd > RAM_WORDS) begin
               n.st = blps_pkg::ST_FAIL;
               n.fail = 1'h1;
               n.qrun = 1'h0;
            end else begin
               n.st = blps_pkg::ST_PROG;
            end
         end
         blps_pkg::ST_PROG: if (wdone) begin
            n.we = 1'h1;
            n.waddr = r.widx[RAM_AW-1:0];
            n.wdata = wd;
            n.widx = r.widx + 32'h00000001;
            if (r.widx + 32'h00000001 == r.len) begin
               n.st = blps_pkg::ST_CHK;
            end
         end
         blps_pkg::ST_CHK: if (wdone) begin
            n.chk = wd;
            n.qrun = 1'h0;
            if (wd == blps_pkg::SKIP_WORD || wd == crc_val) begin
               n.st = blps_pkg::ST_RUN;
               n.run = 1'h1;
            end else begin
               n.st = blps_pkg::ST_FAIL;
               n.fail = 1'h1;
            end
         end
         blps_pkg::ST_OTP, blps_pkg::ST_RUN, blps_pkg::ST_FAIL: begin
         end
      endcase
      // Chip reset pin low forces the hold state
      if (!r.rst_s2) begin
         n.st = blps_pkg::ST_HOLD;
         n.run = 1'h0;
         n.otp = 1'h0;
         n.fail = 1'h0;
         n.qrun = 1'h0;
         n.bcnt = 2'h0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= blps_pkg::ST_HOLD;
         r.ratio <= blps_pkg::BOOT_RST.ratio;
         r.pll <= blps_pkg::BOOT_RST.pll;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = r.rdata;
   assign pready = 1'h1;
   assign pslverr = psel && penable && r.err;
   assign gpio_pulldown_en = r.st == blps_pkg::ST_HOLD;
   assign core_rst = !(r.run || r.otp);
   assign otp_boot = r.otp;
   assign boot_fail = r.fail;
   assign start_addr = blps_pkg::BOOT_PC;
   // One setting drives switch, tile and reference clocks
   assign pll_cfg = r.pll;
   assign ram_we = r.we;
   assign ram_addr = r.waddr;
   assign ram_wdata = r.wdata;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_release;
      r.st == blps_pkg::ST_HOLD && r.rst_s2;
   endsequence
   sequence s_chk_word;
      r.st == blps_pkg::ST_CHK && wdone;
   endsequence
   sequence s_prog_word;
      r.st == blps_pkg::ST_PROG && wdone;
   endsequence
   sequence s_len_word;
      r.st == blps_pkg::ST_LEN && wdone;
   endsequence

   hold_pulldown_a: assert property (!r.rst_s2 |=> gpio_pulldown_en && core_rst)
      else $error("pull-downs off in reset");
   boot_delay_a: assert property ($rose(r.st == blps_pkg::ST_SEL) |->
      $past(r.st == blps_pkg::ST_HOLD, DLY_HIST) && $past(r.st == blps_pkg::ST_DLY))
      else $error("boot delay wrong");
   strap_pll_a: assert property (s_release |=>
      pll_cfg == $past(boot_w.pll) && r.ratio == $past(boot_w.ratio))
      else $error("strap table wrong");
   ratio_form_a: assert property (s_release |=> int'(r.ratio) * 2 *
      (int'(r.pll.pll_output_divider) + 1) * (int'(r.pll.r) + 1) == int'(r.pll.f) + 1)
      else $error("ratio formula broken");
   // Writes land anywhere except the strap load edge, which wins
   pll_write_a: assert property (psel && penable && pwrite &&
      paddr == blps_pkg::OFF_PLLCFG && !(r.st == blps_pkg::ST_HOLD && r.rst_s2) |=>
      pll_cfg.f == $past(pwdata[19:8]) && pll_cfg.r == $past(pwdata[5:0]) &&
      pll_cfg.pll_output_divider == $past(pwdata[26:24]))
      else $error("pll write lost");
   boot_src_a: assert property (r.st == blps_pkg::ST_SEL && r.rst_s2 |=>
      ($past(security_word[blps_pkg::SEC_BOOT_BIT]) ? (otp_boot && !r.qrun) :
      (r.qrun && !otp_boot)) && start_addr == 32'h00000000)
      else $error("boot source wrong");
   prog_store_a: assert property (s_prog_word and r.rst_s2 |=> ram_we &&
      ram_wdata == $past(wd) && ram_addr == $past(r.widx[RAM_AW-1:0]))
      else $error("program word misplaced");
   skip_crc_a: assert property (s_chk_word and
      (wd == blps_pkg::SKIP_WORD && r.rst_s2) |=> r.run && !boot_fail ##1 !core_rst)
      else $error("skip word not honoured");
   crc_fail_a: assert property (s_chk_word and
      (wd != blps_pkg::SKIP_WORD && wd != crc_val && r.rst_s2) |=>
      boot_fail && core_rst && !r.qrun)
      else $error("bad crc not halted");
   // First flash byte must end up in the low byte of the length
   len_lsb_a: assert property (s_len_word and r.rst_s2 |=>
      r.len[31:24] == $past(byte_data) && r.len[7:0] == $past(r.word[15:8]))
      else $error("length byte order wrong");
   // Check word closes the flash frame
   fetch_end_a: assert property (s_chk_word and r.rst_s2 |=> !r.qrun ##1 flash_cs_n)
      else $error("flash read not ended");
   // Secure boot leaves flash and program RAM untouched
   otp_quiet_a: assert property (otp_boot |-> flash_cs_n && !ram_we)
      else $error("flash active in otp boot");
endmodule: blps_boot_top

// ### tb/blps_flash_model.sv
// Behavioural quad-output serial flash holding the boot image
module blps_flash_model (
   input wire logic pclk,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe,
   output logic [3:0] io_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:63];
   logic [31:0] cmd;
   logic [3:0] dq = 4'h5;
   int rises = 0;
   int nib = 0;
   // Wire level: design where enabled, flash elsewhere
   assign io_i = (io_oe & io_o) | (~io_oe & dq);
   // Frame start clears the counts
   always @(negedge cs_n) begin
      rises = 0;
      nib = 0;
   end
   // Command and address shift in on io0, MSB first
   always @(posedge sck) begin
      if (!cs_n && rises < 32) cmd = {cmd[30:0], io_o[0]};
      rises++;
   end
   // Data after the falling clock, high nibble first
   always @(negedge sck) begin
      if (!cs_n && rises >= 40) begin
         dq = nib[0] ? mem[nib[6:1]][3:0] : mem[nib[6:1]][7:4];
         nib++;
      end else begin
         dq = ~dq;
      end
   end
   // Deselected flash leaves the lines moving
   always @(posedge pclk) if (cs_n) dq <= ~dq;
endmodule: blps_flash_model

// ### tb/testbench.sv
// Self-checking bench for the boot sequencer top
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, chip_rst_n, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, security_word, start_addr, ram_wdata, rd, crc_exp;
   logic pready, pslverr, gpio_pulldown_en, core_rst, otp_boot, boot_fail, ram_we;
   logic flash_sck, flash_cs_n;
   logic [3:0] flash_io_o, flash_io_oe, flash_io_i;
   logic [1:0] strap_pins;
   logic [5:0] ram_addr;
   blps_pkg::blps_pll_t pll_cfg;
   logic [31:0] ram [0:63];
   int bad_count = 0, num_checks = 0, cyc = 0, n = 0;
   int rt [4] = '{40, 4, 8, 16};
   blps_boot_top #(.RAM_AW(6)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .chip_rst_n, .strap_pins, .security_word,
      .gpio_pulldown_en, .core_rst, .otp_boot, .boot_fail, .start_addr, .pll_cfg, .ram_we,
      .ram_addr, .ram_wdata, .flash_sck, .flash_cs_n, .flash_io_o, .flash_io_oe, .flash_io_i);
   blps_flash_model fm (.pclk, .sck(flash_sck), .cs_n(flash_cs_n), .io_o(flash_io_o),
      .io_oe(flash_io_oe), .io_i(flash_io_i));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Cycle ceiling and RAM capture
   always @(posedge pclk) begin
      cyc++;
      if (ram_we === 1'b1) ram[ram_addr] <= ram_wdata;
      if (cyc == 30000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask: chk
   // APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk); // Let the write settle before callers compare
   endtask: apb
   // Image: length, two words, check word by mode
   task automatic load(input logic [1:0] mode);
      logic [31:0] w [0:3];
      logic [31:0] c;
      w = '{32'h2, 32'h1234abcd, 32'h0f0e0d0c, 32'h0};
      c = 32'h0fffffff;
      for (int i = 0; i < 12; i++) begin
         c = c ^ {24'h0, w[i / 4][8 * (i % 4) +: 8]};
         repeat (8) c = c[0] ? (c >> 1) ^ blps_pkg::CRC_POLY : c >> 1;
      end
      crc_exp = ~c;
      w[3] = (mode == 2'h1) ? blps_pkg::SKIP_WORD : crc_exp ^ {31'h0, mode[1]};
      for (int i = 0; i < 16; i++) fm.mem[i] = w[i / 4][8 * (i % 4) +: 8];
   endtask: load
   task automatic boot(input logic [1:0] st, input logic sec);
      @(posedge pclk);
      chip_rst_n <= 1'b0;
      strap_pins <= st;
      security_word <= {26'h0, sec, 5'h0};
      repeat (10) @(posedge pclk);
      chk("pulldown", 32'(gpio_pulldown_en), 32'h1);
      chk("core held", 32'(core_rst), 32'h1);
      chip_rst_n <= 1'b1;
      n = 0;
      while (core_rst === 1'b1 && boot_fail !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      repeat (2) @(posedge pclk);
   endtask: boot
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask: summarize
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, chip_rst_n, strap_pins, security_word} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("pll rst", 32'(pll_cfg), 32'({3'h1, 12'h09f, 6'h0}));
      apb(1'b1, blps_pkg::OFF_PLLCFG, 32'h03012305);
      chk("pll wr", 32'(pll_cfg), 32'({3'h3, 12'h123, 6'h05}));
      apb(1'b0, blps_pkg::OFF_PLLCFG, 32'h0);
      chk("pll rd", rd, 32'h03012305);
      chk("pll err", 32'(err), 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      for (int s = 0; s < 4; s++) begin
         boot(s[1:0], 1'b1);
         chk("delay", 32'(n >= 600 && n <= 6000), 32'h1);
         chk("otp", 32'(otp_boot), 32'h1);
         chk("pll", 32'(pll_cfg), 32'({3'h1, 12'(4 * rt[s] - 1), 6'h0}));
         apb(1'b0, blps_pkg::OFF_STATUS, 32'h0);
         chk("ratio", {24'h0, rd[31:24]}, 32'(rt[s]));
         apb(1'b0, blps_pkg::OFF_SECURE, 32'h0);
         chk("secure", rd, 32'h00000020);
      end
      for (int m = 0; m < 3; m++) begin
         load(m[1:0]);
         boot(2'h2, 1'b0);
         chk("otp off", 32'(otp_boot), 32'h0);
         chk("fail", 32'(boot_fail), 32'(m == 2));
         chk("core", 32'(core_rst), 32'(m == 2));
         chk("cmd", fm.cmd, {blps_pkg::FL_CMD, blps_pkg::FL_ADDR});
         if (m == 0) begin
            chk("ram0", ram[0], 32'h1234abcd);
            chk("ram1", ram[1], 32'h0f0e0d0c);
            chk("start", start_addr, 32'h0);
            apb(1'b0, blps_pkg::OFF_LENGTH, 32'h0);
            chk("length", rd, 32'h2);
            apb(1'b0, blps_pkg::OFF_CRC, 32'h0);
            chk("crc", rd, crc_exp);
            apb(1'b0, blps_pkg::OFF_CHECK, 32'h0);
            chk("check", rd, crc_exp);
            apb(1'b1, blps_pkg::OFF_PLLCFG, 32'h0201f003);
            chk("pll retune", 32'(pll_cfg), 32'({3'h2, 12'h1f0, 6'h03}));
         end
      end
      summarize();
   end
endmodule: testbench
